//--- core/cfg_access_pkg.sv
// Purpose: Shared constants and types for the configuration register access responder.
// Assumes: Tokens arrive one per cycle as a control flag plus an 8-bit value.
// Notes: Multi-byte fields travel most significant byte first.
package cfg_access_pkg;
    localparam logic [7:0] CT_CFG_WRITE = 8'hc0;
    localparam logic [7:0] CT_CFG_READ = 8'hc1;
    localparam logic [7:0] CT_PER_WRITE = 8'h24;
    localparam logic [7:0] CT_PER_READ = 8'h25;
    localparam logic [7:0] CT_END = 8'h01;
    localparam logic [7:0] CT_ACK = 8'h03;
    localparam logic [7:0] CT_NACK = 8'h04;
    localparam logic [7:0] NO_REPLY_CHAN = 8'hff;
    localparam int CFG_REGS = 16;
    localparam int PER_REGS = 64;
    localparam int FIFO_DEPTH = 16;
    localparam logic [31:0] CFG_RESET_VAL = 32'h0000_0000;
    localparam logic [7:0] PER_RESET_VAL = 8'h00;
    localparam logic [1:0] SEL_TILE = 2'h0;
    localparam logic [1:0] SEL_NODE = 2'h1;
    localparam logic [1:0] SEL_PERIPH = 2'h2;

    typedef struct packed {
        logic ctrl;
        logic [7:0] value;
    } token_t;
endpackage : cfg_access_pkg

//--- core/cfg_access.sv
// Purpose: Register access responder decoding request token streams and replying with token responses.
// Assumes: One request at a time; a reply is fully queued before the next request is taken.
// Notes: Replies pass through a 16-word FIFO whose ready stalls the request decoder.
// Function
// RL1 - Each request carries a 24-bit return address from the requester.
// RL2 - The return address is node identifier then channel number.
// RL3 - Write requests with return channel byte all ones get no reply.
// RL4 - Multi-byte fields are sent most significant byte first.
// RL5 - Status resource identifier is register number shifted left eight, OR 0x0C.
// RL6 - Status get and set move one full 32-bit word.
// RL7 - Tile configuration requests use the tile configuration destination.
// RL8 - Node configuration requests use the node configuration destination.
// RL9 - Config write: token 192, address, 16-bit register, 32-bit data, token 1.
// RL10 - Config read: token 193, address, 16-bit register, token 1.
// RL11 - Write reply is tokens 3,1 on success or 4,1 on failure.
// RL12 - Config read reply is 3, 32-bit data, 1; failure 4,1.
// RL13 - Peripheral requests use node, peripheral identifier and low byte 02.
// RL14 - Peripheral write 36, read 37, with register, size, ending token 1.
// RL15 - Peripheral read reply is 3, requested bytes, 1; failure 4,1.
// RL16 - Unknown opener, unknown register or bad length gives failure reply.
`timescale 1ns/1ps

module token_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : token_fifo

module cfg_access (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [1:0] dest_sel,
    input wire cfg_access_pkg::token_t req_token,
    input wire logic req_valid,
    output logic req_ready,
    output cfg_access_pkg::token_t rsp_token,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [23:0] rsp_dest,
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FIELD = 3'b001,
        ST_DATA = 3'b010,
        ST_END = 3'b011,
        ST_DRAIN = 3'b100,
        ST_REPLY = 3'b101
    } state_t;

    state_t state_r;
    logic [7:0] op_r;
    logic [1:0] sel_r;
    logic [3:0] idx_r;
    logic [23:0] ret_r;
    logic [15:0] reg_r;
    logic [7:0] size_r;
    logic [31:0] wdata_r;
    logic [7:0] pcnt_r;
    logic bad_r;
    logic [7:0] ridx_r;
    logic [31:0] cfg_tile [cfg_access_pkg::CFG_REGS];
    logic [31:0] cfg_node [cfg_access_pkg::CFG_REGS];
    logic [7:0] per_mem [cfg_access_pkg::PER_REGS];
    cfg_access_pkg::token_t q_tok;
    logic q_valid;
    logic q_ready;
    logic take;
    logic is_cfg;
    logic is_write;
    logic [3:0] hdr_len;
    logic reg_ok;
    logic suppress;
    logic [7:0] rep_len;

    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
        byte_of = w[31 - 8*k -: 8];
    endfunction : byte_of

    assign take = req_valid && req_ready;
    assign is_cfg = (op_r == cfg_access_pkg::CT_CFG_WRITE) || (op_r == cfg_access_pkg::CT_CFG_READ);
    assign is_write = (op_r == cfg_access_pkg::CT_CFG_WRITE) || (op_r == cfg_access_pkg::CT_PER_WRITE);
    assign hdr_len = is_cfg ? 4'd5 : 4'd5;
    assign req_ready = (state_r == ST_IDLE) || (state_r == ST_FIELD) || (state_r == ST_DATA)
                       || (state_r == ST_END) || (state_r == ST_DRAIN);
    assign busy = (state_r != ST_IDLE);
    assign rsp_dest = ret_r;

    // Register number legality per bank.
    always_comb begin
        reg_ok = 1'b0;
        if (is_cfg) begin
            reg_ok = (reg_r < 16'(cfg_access_pkg::CFG_REGS)) && (sel_r != cfg_access_pkg::SEL_PERIPH); // RL16
        end else begin
            reg_ok = ({8'h00, reg_r[7:0]} + {8'h00, size_r} <= 16'(cfg_access_pkg::PER_REGS))
                     && (size_r != 8'h00) && (sel_r == cfg_access_pkg::SEL_PERIPH); // RL16
        end
    end

    assign suppress = is_write && (ret_r[7:0] == cfg_access_pkg::NO_REPLY_CHAN); // RL3
    assign rep_len = bad_r ? 8'd2 : (is_write ? 8'd2 : (is_cfg ? 8'd6 : size_r + 8'd2));

    // Request decoder.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= ST_IDLE;
            op_r <= 8'h00;
            sel_r <= cfg_access_pkg::SEL_TILE;
            idx_r <= 4'h0;
            ret_r <= 24'h000000;
            reg_r <= 16'h0000;
            size_r <= 8'h00;
            wdata_r <= 32'h00000000;
            pcnt_r <= 8'h00;
            bad_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (take && req_token.ctrl) begin
                        op_r <= req_token.value;
                        sel_r <= dest_sel;
                        idx_r <= 4'h0;
                        reg_r <= 16'h0000;
                        size_r <= 8'h00;
                        pcnt_r <= 8'h00;
                        bad_r <= !(req_token.value == cfg_access_pkg::CT_CFG_WRITE
                                   || req_token.value == cfg_access_pkg::CT_CFG_READ
                                   || req_token.value == cfg_access_pkg::CT_PER_WRITE
                                   || req_token.value == cfg_access_pkg::CT_PER_READ); // RL16
                        state_r <= (req_token.value == cfg_access_pkg::CT_END) ? ST_IDLE : ST_FIELD;
                    end
                end
                ST_FIELD: begin
                    if (take) begin
                        if (req_token.ctrl) begin
                            bad_r <= 1'b1; // RL16
                            state_r <= (req_token.value == cfg_access_pkg::CT_END) ? ST_REPLY : ST_DRAIN;
                        end else if (bad_r) begin
                            state_r <= ST_DRAIN;
                        end else begin
                            if (idx_r < 4'd3) begin
                                ret_r <= {ret_r[15:0], req_token.value}; // RL1 RL2 RL4
                            end else if (is_cfg) begin
                                reg_r <= {reg_r[7:0], req_token.value}; // RL9 RL10 RL4
                            end else if (idx_r == 4'd3) begin
                                reg_r <= {8'h00, req_token.value}; // RL14
                            end else begin
                                size_r <= req_token.value; // RL14
                            end
                            idx_r <= idx_r + 4'd1;
                            if (idx_r == hdr_len - 4'd1) begin
                                idx_r <= 4'h0;
                                state_r <= (op_r == cfg_access_pkg::CT_CFG_WRITE
                                            || op_r == cfg_access_pkg::CT_PER_WRITE) ? ST_DATA : ST_END;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (take) begin
                        if (req_token.ctrl) begin
                            bad_r <= 1'b1; // RL16
                            state_r <= (req_token.value == cfg_access_pkg::CT_END) ? ST_REPLY : ST_DRAIN;
                        end else if (is_cfg) begin
                            wdata_r <= {wdata_r[23:0], req_token.value}; // RL9 RL4
                            idx_r <= idx_r + 4'd1;
                            if (idx_r == 4'd3) begin
                                state_r <= ST_END;
                            end
                        end else begin
                            pcnt_r <= pcnt_r + 8'd1;
                            if (pcnt_r + 8'd1 == size_r) begin
                                state_r <= ST_END;
                            end
                        end
                    end
                end
                ST_END: begin
                    if (take) begin
                        if (!(req_token.ctrl && req_token.value == cfg_access_pkg::CT_END)) begin
                            bad_r <= 1'b1; // RL16
                        end else if (!reg_ok) begin
                            bad_r <= 1'b1; // RL16
                        end
                        state_r <= (req_token.ctrl && req_token.value == cfg_access_pkg::CT_END) ? ST_REPLY : ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (take && req_token.ctrl && req_token.value == cfg_access_pkg::CT_END) begin
                        state_r <= ST_REPLY;
                    end
                end
                ST_REPLY: begin
                    if (suppress || (q_ready && ridx_r == rep_len - 8'd1)) begin
                        state_r <= ST_IDLE; // RL3
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Configuration register storage; peripheral bytes are written as they arrive.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < cfg_access_pkg::CFG_REGS; i++) begin
                cfg_tile[i] <= cfg_access_pkg::CFG_RESET_VAL;
                cfg_node[i] <= cfg_access_pkg::CFG_RESET_VAL;
            end
            for (int i = 0; i < cfg_access_pkg::PER_REGS; i++) begin
                per_mem[i] <= cfg_access_pkg::PER_RESET_VAL;
            end
        end else if (state_r == ST_END && take && req_token.ctrl && req_token.value == cfg_access_pkg::CT_END
                     && reg_ok && !bad_r) begin
            if (op_r == cfg_access_pkg::CT_CFG_WRITE && sel_r == cfg_access_pkg::SEL_TILE) begin
                cfg_tile[reg_r[3:0]] <= wdata_r; // RL6 RL9
            end else if (op_r == cfg_access_pkg::CT_CFG_WRITE) begin
                cfg_node[reg_r[3:0]] <= wdata_r; // RL9
            end
        end else if (state_r == ST_DATA && take && !req_token.ctrl && !is_cfg && reg_ok) begin
            per_mem[6'(reg_r[7:0] + pcnt_r)] <= req_token.value; // RL14
        end
    end

    // Reply sequencer feeding the FIFO.
    always_comb begin
        q_tok = '{ctrl: 1'b1, value: cfg_access_pkg::CT_END};
        if (ridx_r == 8'd0) begin
            q_tok = '{ctrl: 1'b1, value: bad_r ? cfg_access_pkg::CT_NACK : cfg_access_pkg::CT_ACK}; // RL11 RL12 RL15
        end else if (ridx_r != rep_len - 8'd1) begin
            if (is_cfg) begin
                q_tok.ctrl = 1'b0;
                q_tok.value = byte_of(sel_r == cfg_access_pkg::SEL_TILE ? cfg_tile[reg_r[3:0]]
                                      : cfg_node[reg_r[3:0]], 2'(ridx_r - 8'd1)); // RL12 RL4
            end else begin
                q_tok.ctrl = 1'b0;
                q_tok.value = per_mem[6'(reg_r[7:0] + ridx_r - 8'd1)]; // RL15
            end
        end
    end

    assign q_valid = (state_r == ST_REPLY) && !suppress;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ridx_r <= 8'h00;
        end else if (state_r != ST_REPLY) begin
            ridx_r <= 8'h00;
        end else if (q_valid && q_ready) begin
            ridx_r <= ridx_r + 8'd1;
        end
    end

    token_fifo #(.WIDTH(9), .DEPTH(cfg_access_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_data(q_tok),
        .in_valid(q_valid),
        .in_ready(q_ready),
        .out_data(rsp_token),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready)
    );

    chk_suppress_no_reply: assert property (@(posedge clk_sys) disable iff (srst) // RL3
        (state_r == ST_REPLY && suppress) |-> !q_valid ##1 state_r == ST_IDLE)
        else $error("Suppressed write produced a reply.");
    chk_reply_opens_ack: assert property (@(posedge clk_sys) disable iff (srst) // RL11
        (q_valid && ridx_r == 8'd0) |-> q_tok.ctrl && (q_tok.value == (bad_r ? 8'h04 : 8'h03)))
        else $error("Reply does not open with the right status token.");
    chk_reply_ends_end: assert property (@(posedge clk_sys) disable iff (srst) // RL12
        (q_valid && q_ready && ridx_r == rep_len - 8'd1) |-> q_tok.ctrl && q_tok.value == 8'h01 ##1 state_r == ST_IDLE)
        else $error("Reply does not close with the end token.");
    chk_bad_opener_nack: assert property (@(posedge clk_sys) disable iff (srst) // RL16
        (state_r == ST_IDLE && take && req_token.ctrl
         && req_token.value != cfg_access_pkg::CT_CFG_WRITE && req_token.value != cfg_access_pkg::CT_CFG_READ
         && req_token.value != cfg_access_pkg::CT_PER_WRITE && req_token.value != cfg_access_pkg::CT_PER_READ)
        |=> bad_r)
        else $error("Unknown opener was not flagged.");
    chk_write_reply_short: assert property (@(posedge clk_sys) disable iff (srst) // RL11
        (q_valid && is_write && ridx_r == 8'd1) |-> q_tok.ctrl && q_tok.value == cfg_access_pkg::CT_END)
        else $error("Write reply is longer than two tokens.");
    chk_read_data_plain: assert property (@(posedge clk_sys) disable iff (srst) // RL12
        (q_valid && op_r == cfg_access_pkg::CT_CFG_READ && !bad_r && ridx_r >= 8'd1 && ridx_r <= 8'd4)
        |-> !q_tok.ctrl)
        else $error("Read data byte was sent as a control token.");
endmodule : cfg_access

//--- tb/req_model.sv
// Purpose: Requester model that streams request tokens and takes reply tokens.
// Assumes: The bench fills send_q with words of bank select, control flag and value.
// Notes: Reply acceptance stalls at random, and fully while stall is high.
`timescale 1ns/1ps

module req_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic stall,
    output logic [1:0] dest_sel,
    output cfg_access_pkg::token_t req_token,
    output logic req_valid,
    input wire logic req_ready,
    output logic rsp_ready
);
    logic [10:0] send_q[$];
    logic [10:0] word;

    initial begin
        dest_sel = 2'h0;
        req_token = '0;
        req_valid = 1'b0;
        rsp_ready = 1'b0;
    end

    // Each token is held until taken; an idle line inverts the last token on every clock.
    always @(posedge clk_sys) begin
        if (srst) begin
            req_valid <= 1'b0;
        end else if (!req_valid || req_ready) begin
            if (send_q.size() > 0) begin
                word = send_q.pop_front();
                dest_sel <= word[10:9];
                req_token <= word[8:0];
                req_valid <= 1'b1;
            end else begin
                req_token <= ~req_token;
                req_valid <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys) begin
        rsp_ready <= !srst && !stall && ($urandom_range(3) != 0);
    end
endmodule : req_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the configuration register access responder.
// Assumes: The requester model sends queued tokens; replies are checked in order.
// Notes: Expected replies come from a shadow copy of the register banks.
`timescale 1ns/1ps

module tb_top;
    logic clk_sys, srst, stall, req_valid, req_ready, rsp_valid, rsp_ready, busy;
    logic [1:0] dest_sel;
    logic [23:0] rsp_dest;
    cfg_access_pkg::token_t req_token, rsp_token;
    logic [8:0] exp_q[$];
    logic [31:0] cmem[2][16];
    logic [7:0] pmem[64];
    logic [15:0] r;
    int num_errors = 0;
    int n_tests = 0;

    cfg_access u_dut (.clk_sys(clk_sys), .srst(srst), .dest_sel(dest_sel), .req_token(req_token),
        .req_valid(req_valid), .req_ready(req_ready), .rsp_token(rsp_token), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_dest(rsp_dest), .busy(busy));
    req_model u_req (.clk_sys(clk_sys), .srst(srst), .stall(stall), .dest_sel(dest_sel),
        .req_token(req_token), .req_valid(req_valid), .req_ready(req_ready), .rsp_ready(rsp_ready));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task put(input logic [1:0] s, input logic c, input logic [7:0] v);
        u_req.send_q.push_back({s, c, v});
    endtask : put

    task hdr(input logic [1:0] s, input logic [7:0] op, input logic [23:0] ret);
        put(s, 1'b1, op);
        for (int i = 2; i >= 0; i--) put(s, 1'b0, ret[i*8 +: 8]);
    endtask : hdr

    task reply(input logic ok, input int n, input logic [31:0] v);
        exp_q.push_back({1'b1, ok ? cfg_access_pkg::CT_ACK : cfg_access_pkg::CT_NACK});
        for (int i = n - 1; i >= 0; i--) if (ok) exp_q.push_back({1'b0, v[i*8 +: 8]});
        exp_q.push_back({1'b1, cfg_access_pkg::CT_END});
    endtask : reply

    task cfg_wr(input logic [1:0] s, input logic [23:0] ret, input logic [15:0] a, input logic [31:0] v);
        logic ok;
        ok = s != cfg_access_pkg::SEL_PERIPH && a < cfg_access_pkg::CFG_REGS;
        hdr(s, cfg_access_pkg::CT_CFG_WRITE, ret);
        for (int i = 5; i >= 0; i--) put(s, 1'b0, i > 3 ? a[(i-4)*8 +: 8] : v[i*8 +: 8]);
        put(s, 1'b1, cfg_access_pkg::CT_END);
        if (ok) cmem[s[0]][a[3:0]] = v;
        if (ret[7:0] != cfg_access_pkg::NO_REPLY_CHAN) reply(ok, 0, 0);
    endtask : cfg_wr

    task cfg_rd(input logic [1:0] s, input logic [23:0] ret, input logic [15:0] a, input logic cut);
        logic ok;
        ok = s != cfg_access_pkg::SEL_PERIPH && a < cfg_access_pkg::CFG_REGS && !cut;
        hdr(s, cfg_access_pkg::CT_CFG_READ, ret);
        if (!cut) put(s, 1'b0, a[15:8]);
        put(s, 1'b0, a[7:0]);
        put(s, 1'b1, cfg_access_pkg::CT_END);
        reply(ok, 4, cmem[s[0]][a[3:0]]);
    endtask : cfg_rd

    task per_op(input logic wr, input logic [23:0] ret, input logic [7:0] a, input logic [7:0] n);
        logic ok;
        logic [7:0] b;
        logic [31:0] v;
        ok = n != 0 && int'(a) + int'(n) <= cfg_access_pkg::PER_REGS;
        v = '0;
        hdr(2'h2, wr ? cfg_access_pkg::CT_PER_WRITE : cfg_access_pkg::CT_PER_READ, ret);
        put(2'h2, 1'b0, a);
        put(2'h2, 1'b0, n);
        for (int i = 0; i < n; i++) begin
            b = $urandom;
            if (wr) put(2'h2, 1'b0, b);
            if (wr && ok) pmem[a + i] = b;
            if (ok) v = {v[23:0], pmem[a + i]};
        end
        put(2'h2, 1'b1, cfg_access_pkg::CT_END);
        reply(ok, wr ? 0 : int'(n), v);
    endtask : per_op

    task drain;
        for (int i = 0; i < 3000 && (u_req.send_q.size() > 0 || exp_q.size() > 0 || busy !== 1'b0); i++)
            @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        #1;
        check("requests outstanding", u_req.send_q.size(), 0);
        check("replies outstanding", exp_q.size(), 0);
        check("reply fifo valid", rsp_valid, 0);
        check("responder idle", busy, 0);
    endtask : drain

    // Takes the oldest expected token whenever a reply token is accepted.
    always @(posedge clk_sys) begin
        if (!srst && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            if (exp_q.size() == 0)
                check("unexpected reply token", rsp_token, 32'hffff_ffff);
            else
                check("reply token", rsp_token, exp_q.pop_front());
        end
    end

    initial begin
        #300us;
        num_errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(8));
        foreach (cmem[a, b]) cmem[a][b] = cfg_access_pkg::CFG_RESET_VAL;
        foreach (pmem[a]) pmem[a] = cfg_access_pkg::PER_RESET_VAL;
        srst = 1'b1;
        stall = 1'b0;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        cfg_rd(2'h0, 24'h000105, 16'h0003, 1'b0);
        for (int i = 0; i < 8; i++) begin
            r = $urandom_range(15);
            cfg_wr(2'(i % 2), 24'h000105, r, $urandom);
            cfg_rd(2'(i % 2), 24'h000106, r, 1'b0);
        end
        cfg_wr(2'h1, 24'h0001ff, 16'h000f, 32'ha5a5_0f0f);
        cfg_rd(2'h1, 24'h000107, 16'h000f, 1'b0);
        cfg_wr(2'h0, 24'h000108, 16'h0010, 32'h1234_5678);
        cfg_rd(2'h0, 24'h000108, 16'h0100, 1'b0);
        cfg_rd(2'h0, 24'h000108, 16'h0005, 1'b1);
        cfg_wr(2'h2, 24'h000108, 16'h0002, 32'h0000_0001);
        hdr(2'h0, 8'h55, 24'h000109);
        put(2'h0, 1'b1, cfg_access_pkg::CT_END);
        reply(1'b0, 0, 0);
        per_op(1'b1, 24'h00010a, 8'd62, 8'd2);
        per_op(1'b0, 24'h00010a, 8'd61, 8'd3);
        per_op(1'b1, 24'h00010a, 8'd0, 8'd4);
        per_op(1'b0, 24'h00010a, 8'd0, 8'd4);
        per_op(1'b1, 24'h00010a, 8'd10, 8'd0);
        per_op(1'b0, 24'((24'h0000a1 << 8) | 24'h00000c), 8'd62, 8'd4);
        drain();
        check("return address", rsp_dest, 24'h00a10c);
        stall <= 1'b1;
        for (int i = 0; i < 4; i++) cfg_rd(2'h0, 24'h00010b, 16'(i), 1'b0);
        repeat (150) @(posedge clk_sys);
        #1;
        check("requests held back", u_req.send_q.size() > 0, 1);
        check("replies waiting", rsp_valid, 1);
        stall <= 1'b0;
        drain();
        wrap_up();
    end
endmodule : tb_top
